// ### src/jlc_pkg.sv
package jlc_pkg;

  // Register map
  localparam logic [12:0] JLC_LANE_RATE_OFS   = 13'h056e;
  localparam logic [12:0] JLC_QUICK_SETUP_OFS = 13'h0570;

  // Reset values
  localparam logic [7:0]  JLC_LANE_RATE_RST   = 8'h00;
  localparam logic [7:0]  JLC_QUICK_SETUP_RST = 8'h88;

  // Field positions in lane_rate_range_control
  localparam int          JLC_LOW_RATE_BIT    = 4;
  localparam int          JLC_PLL_RATE_LSB    = 3;
  localparam int          JLC_PLL_RATE_W      = 2;

  // Resolution and control-bit limits per padded sample width
  localparam logic [4:0]  JLC_N16_MIN         = 5'h08;
  localparam logic [4:0]  JLC_N16_MAX         = 5'h10;
  localparam logic [1:0]  JLC_CS16_MAX        = 2'h3;
  localparam logic [4:0]  JLC_N8_MIN          = 5'h07;
  localparam logic [4:0]  JLC_N8_MAX          = 5'h08;
  localparam logic [1:0]  JLC_CS8_MAX         = 2'h1;

  // Lane count
  localparam int          JLC_LANES           = 4;

  typedef struct packed {
    logic       valid;
    logic [2:0] l;
    logic [2:0] m;
    logic [3:0] f;
    logic [3:0] s;
    logic       hd;
  } jlc_qcfg_s;

  typedef enum logic [1:0] {
    JLC_LINK_DOWN = 2'b01,
    JLC_LINK_UP   = 2'b10
  } jlc_link_e;

endpackage : jlc_pkg

// ### src/jlc_link_config.sv
// Summary of operation
// R1: All four lanes form one link together; the code enables only the lowest L lanes (1, 2 or 4).
// R2: Quick-setup register at 0x570 selects link parameters.
// R3: Host computes lane rate from M, N', L.
// R4: Output rate is sample rate over decimation.
// R5: Host keeps lane rate within 3.125-12.5 Gbps.
// R6: Host powers down, configures, then powers up.
// R7: Below 6.25 Gbps host writes 0x10 to 0x56E.
// R8: At 6.25 Gbps and above, low-rate bit cleared.
// R9: Decode 16-bit sample quick-setup code table.
// R10: Decode 8-bit sample quick-setup code table.
// R11: Host picks K multiple of four, F-based minimum.
// R12: Host sets PLL lane-rate field to match.
`timescale 1ns/1ps
`default_nettype none

module jlc_link_config
  import jlc_pkg::*;
(
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  // Register port
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic [12:0]               reg_addr,
  input  wire logic [7:0]                reg_wdata,
  output logic      [7:0]                reg_rdata,
  // Link control
  input  wire logic                      link_pwdn,
  input  wire logic                      sample_width_8,
  // Active link configuration
  output logic                           link_up,
  output logic                           cfg_valid,
  output logic      [2:0]                cfg_lanes,
  output logic      [2:0]                cfg_converters,
  output logic      [3:0]                cfg_octets,
  output logic      [3:0]                cfg_samples,
  output logic                           cfg_high_density,
  output logic                           cfg_width_8,
  output logic      [4:0]                cfg_res_min,
  output logic      [4:0]                cfg_res_max,
  output logic      [1:0]                cfg_ctrl_max,
  output logic      [JLC_LANES-1:0]      lane_enable,
  output logic                           low_line_rate,
  output logic      [JLC_PLL_RATE_W-1:0] pll_rate_sel
);

  function automatic jlc_qcfg_s qcfg(input logic [2:0] l, input logic [2:0] m,
                                     input logic [3:0] f, input logic [3:0] s,
                                     input logic hd);
    jlc_qcfg_s r;
    r.valid = 1'b1;
    r.l     = l;
    r.m     = m;
    r.f     = f;
    r.s     = s;
    r.hd    = hd;
    return r;
  endfunction : qcfg

  // Unlisted codes decode invalid and the lanes stay off
  function automatic jlc_qcfg_s decode(input logic [7:0] code, input logic w8);
    jlc_qcfg_s r;
    r = '0;
    if (!w8) begin
      unique case (code) // [R9]
        8'h01:   r = qcfg(3'd1, 3'd1, 4'd2, 4'd1, 1'b0);
        8'h40:   r = qcfg(3'd2, 3'd1, 4'd1, 4'd1, 1'b1);
        8'h41:   r = qcfg(3'd2, 3'd1, 4'd2, 4'd2, 1'b0);
        8'h80:   r = qcfg(3'd4, 3'd1, 4'd1, 4'd2, 1'b1);
        8'h81:   r = qcfg(3'd4, 3'd1, 4'd2, 4'd4, 1'b0);
        8'h0a:   r = qcfg(3'd1, 3'd2, 4'd4, 4'd1, 1'b0);
        8'h49:   r = qcfg(3'd2, 3'd2, 4'd2, 4'd1, 1'b0);
        8'h88:   r = qcfg(3'd4, 3'd2, 4'd1, 4'd1, 1'b1);
        8'h89:   r = qcfg(3'd4, 3'd2, 4'd2, 4'd2, 1'b0);
        8'h13:   r = qcfg(3'd1, 3'd4, 4'd8, 4'd1, 1'b0);
        8'h52:   r = qcfg(3'd2, 3'd4, 4'd4, 4'd1, 1'b0);
        8'h91:   r = qcfg(3'd4, 3'd4, 4'd2, 4'd1, 1'b0);
        default: r = '0;
      endcase
    end else begin
      unique case (code) // [R10]
        8'h00:   r = qcfg(3'd1, 3'd1, 4'd1, 4'd1, 1'b0);
        8'h01:   r = qcfg(3'd1, 3'd1, 4'd2, 4'd2, 1'b0);
        8'h40:   r = qcfg(3'd2, 3'd1, 4'd1, 4'd2, 1'b0);
        8'h41:   r = qcfg(3'd2, 3'd1, 4'd2, 4'd4, 1'b0);
        8'h42:   r = qcfg(3'd2, 3'd1, 4'd4, 4'd8, 1'b0);
        8'h80:   r = qcfg(3'd4, 3'd1, 4'd1, 4'd4, 1'b0);
        8'h81:   r = qcfg(3'd4, 3'd1, 4'd2, 4'd8, 1'b0);
        8'h09:   r = qcfg(3'd1, 3'd2, 4'd2, 4'd1, 1'b0);
        8'h48:   r = qcfg(3'd2, 3'd2, 4'd1, 4'd1, 1'b0);
        8'h49:   r = qcfg(3'd2, 3'd2, 4'd2, 4'd2, 1'b0);
        8'h88:   r = qcfg(3'd4, 3'd2, 4'd1, 4'd2, 1'b0);
        8'h89:   r = qcfg(3'd4, 3'd2, 4'd2, 4'd4, 1'b0);
        8'h8a:   r = qcfg(3'd4, 3'd2, 4'd4, 4'd8, 1'b0);
        default: r = '0;
      endcase
    end
    return r;
  endfunction : decode

  // Registers
  logic [7:0] lane_rate_q,   lane_rate_d;
  logic [7:0] quick_setup_q, quick_setup_d;
  logic [7:0] rdata_q,       rdata_d;

  always_comb begin
    lane_rate_d   = lane_rate_q;
    quick_setup_d = quick_setup_q;
    rdata_d       = rdata_q;
    if (reg_wr && reg_addr == JLC_LANE_RATE_OFS) begin
      lane_rate_d = reg_wdata; // [R7] [R8] [R12]
    end
    if (reg_wr && reg_addr == JLC_QUICK_SETUP_OFS) begin
      quick_setup_d = reg_wdata; // [R2]
    end
    if (reg_rd) begin
      unique case (reg_addr)
        JLC_LANE_RATE_OFS:   rdata_d = lane_rate_q;
        JLC_QUICK_SETUP_OFS: rdata_d = quick_setup_q;
        default:             rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lane_rate_q   <= JLC_LANE_RATE_RST;
      quick_setup_q <= JLC_QUICK_SETUP_RST;
      rdata_q       <= 8'h00;
    end else begin
      lane_rate_q   <= lane_rate_d;
      quick_setup_q <= quick_setup_d;
      rdata_q       <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // Link state and active configuration.
  // Settings are captured only while the link is down, so a write while
  // running cannot tear the lane parameters under the receiver.
  jlc_link_e   state_q,  state_d;
  jlc_qcfg_s   act_q,    act_d;
  logic        w8_q,     w8_d;
  logic        low_q,    low_d;
  logic [1:0]  pll_q,    pll_d;
  logic [JLC_LANES-1:0] lanes_q, lanes_d;
  jlc_qcfg_s   dec;
  // Limits registered so every output leaves a flip-flop
  logic        up_q,     up_d;
  logic [4:0]  rmin_q,   rmin_d;
  logic [4:0]  rmax_q,   rmax_d;
  logic [1:0]  cmax_q,   cmax_d;

  always_comb begin
    dec     = decode(quick_setup_q, sample_width_8);
    state_d = state_q;
    act_d   = act_q;
    w8_d    = w8_q;
    low_d   = low_q;
    pll_d   = pll_q;
    lanes_d = lanes_q;
    unique case (state_q)
      JLC_LINK_DOWN: begin // [R6]
        act_d   = dec;
        w8_d    = sample_width_8;
        // Host folds decimation into the rate it programs [R4]
        low_d   = lane_rate_q[JLC_LOW_RATE_BIT]; // [R7] [R8]
        pll_d   = lane_rate_q[JLC_PLL_RATE_LSB +: JLC_PLL_RATE_W]; // [R12]
        lanes_d = '0;
        if (!link_pwdn && dec.valid) begin
          state_d = JLC_LINK_UP;
          // One link: lanes enabled together from L [R1]
          unique case (dec.l)
            3'd1:    lanes_d = 4'b0001;
            3'd2:    lanes_d = 4'b0011;
            default: lanes_d = 4'b1111;
          endcase
        end
      end
      JLC_LINK_UP: begin
        if (link_pwdn) begin
          state_d = JLC_LINK_DOWN;
          lanes_d = '0; // [R1]
        end
      end
    endcase
    up_d   = state_d == JLC_LINK_UP;
    rmin_d = w8_d ? JLC_N8_MIN : JLC_N16_MIN; // [R9] [R10]
    rmax_d = w8_d ? JLC_N8_MAX : JLC_N16_MAX;
    cmax_d = w8_d ? JLC_CS8_MAX : JLC_CS16_MAX;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= JLC_LINK_DOWN;
      act_q   <= '0;
      w8_q    <= 1'b0;
      low_q   <= 1'b0;
      pll_q   <= 2'b00;
      lanes_q <= '0;
      up_q    <= 1'b0;
      rmin_q  <= JLC_N16_MIN;
      rmax_q  <= JLC_N16_MAX;
      cmax_q  <= JLC_CS16_MAX;
    end else begin
      state_q <= state_d;
      act_q   <= act_d;
      w8_q    <= w8_d;
      low_q   <= low_d;
      pll_q   <= pll_d;
      lanes_q <= lanes_d;
      up_q    <= up_d;
      rmin_q  <= rmin_d;
      rmax_q  <= rmax_d;
      cmax_q  <= cmax_d;
    end
  end

  assign link_up          = up_q;
  assign cfg_valid        = act_q.valid;
  assign cfg_lanes        = act_q.l;
  assign cfg_converters   = act_q.m;
  assign cfg_octets       = act_q.f;
  assign cfg_samples      = act_q.s;
  assign cfg_high_density = act_q.hd;
  assign cfg_width_8      = w8_q;
  assign cfg_res_min      = rmin_q; // [R9] [R10]
  assign cfg_res_max      = rmax_q;
  assign cfg_ctrl_max     = cmax_q;
  assign lane_enable      = lanes_q;
  assign low_line_rate    = low_q;
  assign pll_rate_sel     = pll_q;

endmodule : jlc_link_config

`default_nettype wire

// ### test/jlc_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module jlc_rx_model (
  // Clock and lanes
  input  wire logic       mclk,
  input  wire logic [3:0] lane_enable,
  // Lanes seen
  output logic      [2:0] rx_lanes
);
  // One link, so live lanes equal L
  // Frames per multiframe stay on this side of the link
  always_ff @(posedge mclk) begin
    rx_lanes <= 3'($countones(lane_enable));
  end
endmodule : jlc_rx_model
`default_nettype wire

// ### test/jlc_link_config_properties.sv
`timescale 1ns/1ps
`default_nettype none
module jlc_link_config_chk (
  input wire logic       mclk, rst_n, link_pwdn, link_up, cfg_valid,
  input wire logic       cfg_width_8, cfg_high_density, low_line_rate,
  input wire logic [2:0] cfg_lanes,
  input wire logic [3:0] lane_enable,
  input wire logic [4:0] cfg_res_min, cfg_res_max,
  input wire logic [1:0] cfg_ctrl_max, pll_rate_sel
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_LANES: assert property (link_up |-> lane_enable == 4'((5'h1 << cfg_lanes) - 5'h1))
    else $error("lane mask wrong");
  AST_DOWN: assert property (!link_up |-> lane_enable == 4'h0)
    else $error("lanes live while down");
  AST_PWDN: assert property (link_pwdn |=> !link_up && lane_enable == 4'h0)
    else $error("link not down");
  AST_VALID: assert property (link_up |-> cfg_valid)
    else $error("link up on bad code");
  AST_FREEZE: assert property ($past(link_up) && link_up |-> $stable(cfg_lanes))
    else $error("setup moved while up");
  AST_RES16: assert property (!cfg_width_8 |-> cfg_res_min == 5'h08 && cfg_res_max == 5'h10
    && cfg_ctrl_max == 2'h3) else $error("wide limits wrong");
  AST_RES8: assert property (cfg_width_8 |-> cfg_res_min == 5'h07 && cfg_res_max == 5'h08
    && cfg_ctrl_max == 2'h1) else $error("narrow limits wrong");
  AST_HD8: assert property (cfg_width_8 |-> !cfg_high_density)
    else $error("density set on narrow");
  AST_RATE: assert property (low_line_rate == pll_rate_sel[1])
    else $error("rate bits disagree");
  CVR_UP: cover property ($rose(link_up));
  CVR_N8: cover property (link_up && cfg_width_8);
  CVR_LOW: cover property (link_up && low_line_rate);
endmodule : jlc_link_config_chk
bind jlc_link_config jlc_link_config_chk chk_u (.*);
`default_nettype wire

// ### test/jlc_link_config_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module jlc_link_config_tb_top;
  import jlc_pkg::*;
  logic        mclk, rst_n, reg_wr, reg_rd, link_pwdn, sample_width_8;
  logic [12:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic        link_up, cfg_valid, cfg_high_density, cfg_width_8, low_line_rate;
  logic [2:0]  cfg_lanes, cfg_converters, rx_lanes;
  logic [3:0]  cfg_octets, cfg_samples, lane_enable;
  logic [4:0]  cfg_res_min, cfg_res_max;
  logic [1:0]  cfg_ctrl_max, pll_rate_sel;
  int          n_errors, tests_run, cyc;
  // Nibbles: width, code, L, M, F, S, HD
  logic [31:0] rows [25] = '{32'h00111210, 32'h04021111, 32'h04121220, 32'h08041121,
    32'h08141240, 32'h00a12410, 32'h04922210, 32'h08842111, 32'h08942220, 32'h01314810,
    32'h05224410, 32'h09144210, 32'h10011110, 32'h10111220, 32'h14021120, 32'h14121240,
    32'h14221480, 32'h18041140, 32'h18141280, 32'h10912210, 32'h14822110, 32'h14922220,
    32'h18842120, 32'h18942240, 32'h18a42480};
  jlc_link_config dut_u (.*);
  jlc_rx_model rx_u (.mclk(mclk), .lane_enable(lane_enable), .rx_lanes(rx_lanes));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  // Strobe drops a full cycle before the next access
  task automatic wr(logic [12:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    @(negedge mclk);
  endtask : wr
  task automatic rd(logic [12:0] a, logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    chk("rdata", reg_rdata, e);
    @(negedge mclk);
  endtask : rd
  task automatic up(logic p);
    link_pwdn = p;
    repeat (2) @(negedge mclk);
  endtask : up
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, sample_width_8, rst_n} = '0;
    link_pwdn = 1'b1;
    repeat (5) @(negedge mclk);
    chk("reset", {link_up, lane_enable, reg_rdata}, 0);
    rst_n = 1'b1;
    rd(JLC_QUICK_SETUP_OFS, 8'h88);
    rd(JLC_LANE_RATE_OFS, 8'h00);
    foreach (rows[i]) begin
      sample_width_8 = rows[i][28];
      wr(JLC_QUICK_SETUP_OFS, rows[i][27:20]);
      chk("cfg", {cfg_lanes, cfg_converters, cfg_octets, cfg_samples, cfg_high_density},
        {rows[i][18:16], rows[i][14:12], rows[i][11:8], rows[i][7:4], rows[i][0]});
      chk("limits", {cfg_width_8, cfg_res_min, cfg_res_max, cfg_ctrl_max}, rows[i][28] ?
        {1'b1, JLC_N8_MIN, JLC_N8_MAX, JLC_CS8_MAX} :
        {1'b0, JLC_N16_MIN, JLC_N16_MAX, JLC_CS16_MAX});
      up(1'b0);
      chk("lanes", {link_up, rx_lanes}, {1'b1, rows[i][18:16]});
      link_pwdn = 1'b1;
      @(negedge mclk);
    end
    sample_width_8 = 1'b0;
    wr(JLC_QUICK_SETUP_OFS, 8'h91);
    up(1'b0);
    wr(JLC_QUICK_SETUP_OFS, 8'h01);
    // Host sum gives a 5 Gbps lane, inside range
    wr(JLC_LANE_RATE_OFS, 8'h10);
    chk("frozen", {cfg_lanes, low_line_rate}, 4'h8);
    rd(JLC_QUICK_SETUP_OFS, 8'h01);
    up(1'b1);
    chk("low", {low_line_rate, pll_rate_sel, cfg_lanes}, 6'h31);
    wr(JLC_LANE_RATE_OFS, 8'h00);
    chk("high", {low_line_rate, pll_rate_sel}, 0);
    sample_width_8 = 1'b1;
    wr(JLC_QUICK_SETUP_OFS, 8'h13);
    up(1'b0);
    chk("bad", {link_up, cfg_valid, lane_enable}, 0);
    rd(13'h0571, 8'h00);
    print_verdict();
  end
endmodule : jlc_link_config_tb_top
`default_nettype wire
